// ==== common/scrb_map.vh ====
// Register offsets, field positions and reset values for the serial readback bank
`ifndef SCRB_MAP_VH
`define SCRB_MAP_VH

// Byte offsets of read-back registers (read-only)
`define SCRB_OFF_TC_LOW 8'h00
`define SCRB_OFF_TC_HIGH 8'h04
`define SCRB_OFF_FEAT_RB 8'h08
`define SCRB_OFF_INT_EN_RB 8'h0c
// Byte offsets of write registers that feed the read-backs
`define SCRB_OFF_TC_LOW_WR 8'h10
`define SCRB_OFF_TC_HIGH_WR 8'h14
`define SCRB_OFF_FEAT_WR 8'h18
`define SCRB_OFF_INT_EN_WR 8'h1c
// Clock-loss and loop status, readable directly
`define SCRB_OFF_CLK_LOOP 8'h20

// Field positions
`define SCRB_FEAT_EXT_READ 6
`define SCRB_FEAT_UNUSED 7
`define SCRB_FEAT_TX_FIFO_LVL 5
`define SCRB_FEAT_REQ_TIMING 4
`define SCRB_FEAT_RX_FIFO_LVL 3
`define SCRB_FEAT_AUTO_RTS_OFF 2
`define SCRB_FEAT_AUTO_MSG_END_RST 1
`define SCRB_FEAT_AUTO_TX_FLAG 0
`define SCRB_IE_BREAK_ABORT 7
`define SCRB_IE_TX_UNDERRUN 6
`define SCRB_IE_CLEAR_TO_SEND 5
`define SCRB_IE_SYNC_HUNT 4
`define SCRB_IE_CARRIER_DETECT 3
`define SCRB_IE_SDLC_FIFO 2
`define SCRB_IE_ZERO_COUNT 1
`define SCRB_IE_EXT_FEATURE 0

// Reset values of registers that have a defined reset
`define SCRB_FEAT_RESET 7'h20

`endif

// ==== hw/scrb_regs.v ====
// Read-back register bank of one serial channel, reached over classic Wishbone
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/10ps
`include "scrb_map.vh"

module scrb_regs #(
	parameter AW = 8
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [AW-1:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	output wire err_o,
	// Clock-loss and loop status from the channel
	input wire [7:0] clk_loop_status_i,
	// Programmed settings towards the channel
	output wire [15:0] time_const_o,
	output wire [6:0] feature_ctrl_o,
	output wire [7:0] ext_int_enable_o
);

	// Bus answer sequencer states
	localparam ST_IDLE = 1'b0;
	localparam ST_ANSWER = 1'b1;

	// Request qualification
	reg state_q;
	reg state_d;
	wire req;
	wire req_wr;
	wire req_rd;
	wire lane0_wr;

	// Address decode, one flag per slot
	wire hit_tc_low_rb;
	wire hit_tc_high_rb;
	wire hit_feat_rb;
	wire hit_int_en_rb;
	wire hit_tc_low_wr;
	wire hit_tc_high_wr;
	wire hit_feat_wr;
	wire hit_int_en_wr;
	wire hit_clk_loop;
	wire hit_any;

	// Write strobes into the stored settings
	wire wr_tc_low;
	wire wr_tc_high;
	wire wr_feat;
	wire wr_int_en;

	// Stored settings
	wire [7:0] tc_low_q;
	wire [7:0] tc_high_q;
	wire [7:0] int_en_q;
	reg [6:0] feat_q;
	reg [6:0] feat_d;

	// Feature fields, bit 6 down to bit 0
	wire feat_ext_read;
	wire feat_tx_fifo_lvl;
	wire feat_req_timing;
	wire feat_rx_fifo_lvl;
	wire feat_auto_rts_off;
	wire feat_auto_msg_end_rst;
	wire feat_auto_tx_flag;

	// Interrupt enable fields, bit 7 down to bit 0
	wire ie_break_abort;
	wire ie_tx_underrun;
	wire ie_clear_to_send;
	wire ie_sync_hunt;
	wire ie_carrier_detect;
	wire ie_sdlc_fifo;
	wire ie_zero_count;
	wire ie_ext_feature;

	// Read path
	wire [7:0] tc_low_view;
	wire [7:0] tc_high_view;
	wire [7:0] feat_view;
	wire [7:0] feat_slot;
	wire [7:0] int_en_view;
	reg [7:0] rd_byte_d;
	reg [31:0] dat_d;
	reg ack_d;

	// One request per answer: a held strobe is not taken again while ack stands
	always @* begin
		state_d = state_q;
		case (state_q)
		ST_IDLE: begin
			if (cyc_i && stb_i) begin
				state_d = ST_ANSWER;
			end
		end
		ST_ANSWER: begin
			state_d = ST_IDLE;
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	assign req = cyc_i & stb_i & (state_q == ST_IDLE);
	assign req_wr = req & we_i;
	assign req_rd = req & ~we_i;
	assign lane0_wr = req_wr & sel_i[0];
	assign err_o = 1'b0;

	// Slot decode on the byte address
	assign hit_tc_low_rb = (adr_i == `SCRB_OFF_TC_LOW);
	assign hit_tc_high_rb = (adr_i == `SCRB_OFF_TC_HIGH);
	assign hit_feat_rb = (adr_i == `SCRB_OFF_FEAT_RB);
	assign hit_int_en_rb = (adr_i == `SCRB_OFF_INT_EN_RB);
	assign hit_tc_low_wr = (adr_i == `SCRB_OFF_TC_LOW_WR);
	assign hit_tc_high_wr = (adr_i == `SCRB_OFF_TC_HIGH_WR);
	assign hit_feat_wr = (adr_i == `SCRB_OFF_FEAT_WR);
	assign hit_int_en_wr = (adr_i == `SCRB_OFF_INT_EN_WR);
	assign hit_clk_loop = (adr_i == `SCRB_OFF_CLK_LOOP);
	assign hit_any = hit_tc_low_rb | hit_tc_high_rb | hit_feat_rb | hit_int_en_rb |
		hit_tc_low_wr | hit_tc_high_wr | hit_feat_wr | hit_int_en_wr | hit_clk_loop;

	// Only write-register offsets strobe; read-back offsets ignore writes
	assign wr_tc_low = lane0_wr & hit_tc_low_wr;
	assign wr_tc_high = lane0_wr & hit_tc_high_wr;
	assign wr_feat = lane0_wr & hit_feat_wr;
	assign wr_int_en = lane0_wr & hit_int_en_wr;

	// Time-constant and enable mirrors have no reset
	scrb_mirror_reg #(
		.W(8)
	) u_tc_low (
		.clk_i(clk_i),
		.wr_i(wr_tc_low),
		.dat_i(dat_i[7:0]),
		.q_o(tc_low_q)
	);

	scrb_mirror_reg #(
		.W(8)
	) u_tc_high (
		.clk_i(clk_i),
		.wr_i(wr_tc_high),
		.dat_i(dat_i[7:0]),
		.q_o(tc_high_q)
	);

	scrb_mirror_reg #(
		.W(8)
	) u_int_en (
		.clk_i(clk_i),
		.wr_i(wr_int_en),
		.dat_i(dat_i[7:0]),
		.q_o(int_en_q)
	);

	// Feature register resets with extended read disabled
	always @* begin
		feat_d = feat_q;
		if (wr_feat) begin
			feat_d = dat_i[6:0];
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			feat_q <= `SCRB_FEAT_RESET;
		end else begin
			feat_q <= feat_d;
		end
	end

	// Named feature fields
	assign feat_ext_read = feat_q[`SCRB_FEAT_EXT_READ];
	assign feat_tx_fifo_lvl = feat_q[`SCRB_FEAT_TX_FIFO_LVL];
	assign feat_req_timing = feat_q[`SCRB_FEAT_REQ_TIMING];
	assign feat_rx_fifo_lvl = feat_q[`SCRB_FEAT_RX_FIFO_LVL];
	assign feat_auto_rts_off = feat_q[`SCRB_FEAT_AUTO_RTS_OFF];
	assign feat_auto_msg_end_rst = feat_q[`SCRB_FEAT_AUTO_MSG_END_RST];
	assign feat_auto_tx_flag = feat_q[`SCRB_FEAT_AUTO_TX_FLAG];

	// Named enable fields
	assign ie_break_abort = int_en_q[`SCRB_IE_BREAK_ABORT];
	assign ie_tx_underrun = int_en_q[`SCRB_IE_TX_UNDERRUN];
	assign ie_clear_to_send = int_en_q[`SCRB_IE_CLEAR_TO_SEND];
	assign ie_sync_hunt = int_en_q[`SCRB_IE_SYNC_HUNT];
	assign ie_carrier_detect = int_en_q[`SCRB_IE_CARRIER_DETECT];
	assign ie_sdlc_fifo = int_en_q[`SCRB_IE_SDLC_FIFO];
	assign ie_zero_count = int_en_q[`SCRB_IE_ZERO_COUNT];
	assign ie_ext_feature = int_en_q[`SCRB_IE_EXT_FEATURE];

	// Byte views of each read-back
	assign tc_low_view = tc_low_q;
	assign tc_high_view = tc_high_q;
	assign feat_view = {1'b0, feat_ext_read, feat_tx_fifo_lvl, feat_req_timing,
		feat_rx_fifo_lvl, feat_auto_rts_off, feat_auto_msg_end_rst, feat_auto_tx_flag};
	assign feat_slot = feat_ext_read ? feat_view : clk_loop_status_i;
	assign int_en_view = {ie_break_abort, ie_tx_underrun, ie_clear_to_send, ie_sync_hunt,
		ie_carrier_detect, ie_sdlc_fifo, ie_zero_count, ie_ext_feature};

	// Read multiplexer; write registers read back their stored value
	always @* begin
		rd_byte_d = 8'h00;
		case (adr_i)
		`SCRB_OFF_TC_LOW: begin
			rd_byte_d = tc_low_view;
		end
		`SCRB_OFF_TC_LOW_WR: begin
			rd_byte_d = tc_low_view;
		end
		`SCRB_OFF_TC_HIGH: begin
			rd_byte_d = tc_high_view;
		end
		`SCRB_OFF_TC_HIGH_WR: begin
			rd_byte_d = tc_high_view;
		end
		`SCRB_OFF_FEAT_RB: begin
			rd_byte_d = feat_slot;
		end
		`SCRB_OFF_FEAT_WR: begin
			rd_byte_d = feat_view;
		end
		`SCRB_OFF_INT_EN_RB: begin
			rd_byte_d = int_en_view;
		end
		`SCRB_OFF_INT_EN_WR: begin
			rd_byte_d = int_en_view;
		end
		`SCRB_OFF_CLK_LOOP: begin
			rd_byte_d = clk_loop_status_i;
		end
		default: begin
			rd_byte_d = 8'h00;
		end
		endcase
	end

	// Data holds until the next request; writes and unmapped reads return zero
	always @* begin
		ack_d = req;
		dat_d = dat_o;
		if (req_rd && hit_any) begin
			dat_d = {24'h000000, rd_byte_d};
		end else if (req) begin
			dat_d = 32'h00000000;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= ack_d;
			dat_o <= dat_d;
		end
	end

	assign time_const_o = {tc_high_q, tc_low_q};
	assign feature_ctrl_o = feat_q;
	assign ext_int_enable_o = int_en_q;

endmodule

// Settings mirror without reset, holds its value until software writes it
module scrb_mirror_reg #(
	parameter W = 8
) (
	// Clock
	input wire clk_i,
	// Write port
	input wire wr_i,
	input wire [W-1:0] dat_i,
	// Stored value
	output wire [W-1:0] q_o
);

	reg [W-1:0] val_q;

	// No reset: the value is undefined until the first write
	always @(posedge clk_i) begin
		if (wr_i) begin
			val_q <= dat_i;
		end
	end

	assign q_o = val_q;

endmodule

// ==== test/scrb_regs_chk.sv ====
// Checker for the serial read-back bank
`timescale 1ns/10ps
module scrb_regs_chk #(parameter AW=8)(input wire clk_i,rst_i,we_i,ack_o,
	input wire [AW-1:0] adr_i,input wire [3:0] sel_i,input wire [31:0] dat_i,dat_o,
	input wire [7:0] clk_loop_status_i,ext_int_enable_o,input wire [15:0] time_const_o,
	input wire [6:0] feature_ctrl_o);
	logic [AW-1:0] a_q;logic w_q,e_q;
	always @(posedge clk_i) {a_q,w_q,e_q}<={adr_i,we_i,sel_i[0]};
	wire r=ack_o&!w_q;
	default clocking @(posedge clk_i); endclocking default disable iff (rst_i);
	property p_lo;r&&a_q==8'h00|->dat_o==time_const_o[7:0];endproperty
	a_lo:assert property(p_lo)else $error("low byte");
	property p_hi;r&&a_q==8'h04|->dat_o==time_const_o[15:8];endproperty
	a_hi:assert property(p_hi)else $error("high byte");
	property p_ro;
		ack_o&&w_q&&a_q<8'h10|->$stable({time_const_o,ext_int_enable_o,feature_ctrl_o});
	endproperty
	a_ro:assert property(p_ro)else $error("read-only");
	property p_fe;r&&a_q==8'h08&&!feature_ctrl_o[6]|->dat_o==$past(clk_loop_status_i);endproperty
	a_fe:assert property(p_fe)else $error("status");
	property p_fx;r&&a_q==8'h08&&feature_ctrl_o[6]|->dat_o==feature_ctrl_o;endproperty
	a_fx:assert property(p_fx)else $error("feature");
	property p_ie;r&&a_q==8'h0c|->dat_o==ext_int_enable_o;endproperty
	a_ie:assert property(p_ie)else $error("enables");
	property p_wr;ack_o&&w_q&&e_q&&a_q==8'h10|=>time_const_o[7:0]==$past(dat_i[7:0],2);endproperty
	a_wr:assert property(p_wr)else $error("mirror");
	c_on:cover property(r&&a_q==8'h08&&feature_ctrl_o[6]);
	c_off:cover property(r&&a_q==8'h08&&!feature_ctrl_o[6]);
	c_ro:cover property(ack_o&&w_q&&a_q==8'h00);
endmodule
bind scrb_regs scrb_regs_chk #(.AW(AW)) u_chk(.clk_i(clk_i),.rst_i(rst_i),.we_i(we_i),
	.ack_o(ack_o),.adr_i(adr_i),.sel_i(sel_i),.dat_i(dat_i),.dat_o(dat_o),
	.clk_loop_status_i(clk_loop_status_i),.ext_int_enable_o(ext_int_enable_o),
	.time_const_o(time_const_o),.feature_ctrl_o(feature_ctrl_o));

// ==== test/test_scrb_regs.sv ====
// Testbench for the serial read-back bank
`timescale 1ns/10ps
module test_scrb_regs;
	logic clk_i=0,rst_i=1,cyc_i=0,stb_i=0,we_i=0,ack_o,err_o;
	logic [7:0] adr_i=0,clk_loop_status_i=8'ha5,ext_int_enable_o;logic [3:0] sel_i=4'h1;
	logic [31:0] dat_i=0,dat_o;logic [15:0] time_const_o;logic [6:0] feature_ctrl_o;
	int errors=0,comparisons=0;
	always #12.5 clk_i=~clk_i;
	scrb_regs dut(.*);
	task chk(input logic [31:0] s,e);
		comparisons++;errors+=s!==e;
		if(s!==e) $display("MISMATCH %0t seen %h expected %h",$time,s,e);
	endtask
	// One classic cycle; a read compares the returned byte with e
	task wb(input logic w,input logic [7:0] a,input logic [31:0] d,e);
		logic [31:0] q;
		int n;
		{cyc_i,stb_i,we_i,adr_i,dat_i}<={2'b11,w,a,d};
		n=0;
		@(negedge clk_i);
		while(ack_o!==1&&n<9) begin
			n++;
			@(negedge clk_i);
		end
		if(ack_o!==1) begin
			errors++;
			report_and_stop;
		end
		// Settled mid-cycle; this is the value the master takes at the next rising edge
		q=dat_o;
		@(posedge clk_i);
		{cyc_i,stb_i}<=0;
		@(posedge clk_i);
		if(!w) chk(q,e);
	endtask
	task t_mirror;
		wb(1,8'h10,8'h3c,0);wb(1,8'h14,8'ha5,0);wb(1,8'h1c,8'h96,0);
		wb(0,8'h00,0,8'h3c);
		wb(0,8'h04,0,8'ha5);
		wb(0,8'h0c,0,8'h96);
		chk(time_const_o,16'ha53c);
	endtask
	task t_feat;
		wb(0,8'h08,0,8'ha5);
		wb(1,8'h18,8'hff,0);
		wb(0,8'h08,0,8'h7f);
		chk(feature_ctrl_o,7'h7f);
		wb(0,8'h20,0,8'ha5);
		wb(0,8'h40,0,0);
		chk(err_o,0);
	endtask
	task t_ro;
		for(int i=0;i<16;i+=4) wb(1,i[7:0],0,0);
		wb(0,8'h0c,0,8'h96);
		wb(0,8'h00,0,8'h3c);
		wb(0,8'h08,0,8'h7f);
		chk(ext_int_enable_o,8'h96);
		sel_i<=4'h0;
		wb(1,8'h10,8'hff,0);
		sel_i<=4'h1;
		wb(0,8'h00,0,8'h3c);
	endtask
	task t_reset;
		rst_i<=1;
		repeat(2) @(posedge clk_i);
		rst_i<=0;
		chk(feature_ctrl_o,7'h20);
		wb(0,8'h08,0,8'ha5);
		wb(0,8'h18,0,8'h20);
		wb(0,8'h00,0,8'h3c);
	endtask
	task report_and_stop;
		$display("errors %0d comparisons %0d",errors,comparisons);
		if(errors==0&&comparisons>0) $display("== PASSED =="); else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat(3) @(posedge clk_i);rst_i<=0;
		t_mirror;t_feat;t_ro;t_reset;
		report_and_stop;
	end
endmodule
